// ---- src/fsm_map.vh ----
`ifndef FSM_MAP_VH
`define FSM_MAP_VH
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define FSM_SR_RESET 8'h00
`define FSM_SR_LOCK 7
`define FSM_SR_QUAD_EN 6
`define FSM_SR_BP_HI 5
`define FSM_SR_BP_LO 2
`define FSM_SR_WR_LATCH 1
`define FSM_SR_BUSY 0
// ----------------------------------------
// Commands
// ----------------------------------------
`define FSM_CMD_STATUS_WR 8'h01
`define FSM_CMD_WR_DISABLE 8'h04
`define FSM_CMD_STATUS_RD 8'h05
`define FSM_CMD_WR_ENABLE 8'h06
`define FSM_CMD_SE 8'h20
`define FSM_CMD_PP 8'h02
// ----------------------------------------
// Geometry and timing
// ----------------------------------------
`define FSM_SECTOR_BITS 12
`define FSM_BLK32_BITS 15
`define FSM_BLK64_BITS 16
`define FSM_WRITE_NS 1000
`define FSM_CLK_NS 50
`define FSM_WRITE_CYC ((`FSM_WRITE_NS + `FSM_CLK_NS - 1) / `FSM_CLK_NS)
`endif

// ---- src/fsm_sector_decode.v ----
`timescale 1ns/1ps
`include "fsm_map.vh"
module fsm_sector_decode #(
  parameter ADDR_BITS = 19
) (
  input wire [23:0] addr_in,
  output wire [ADDR_BITS-13:0] sector_out,
  output wire [ADDR_BITS-16:0] block32_out,
  output wire [ADDR_BITS-17:0] block64_out
);
  // Bits above the density are dropped.
  assign sector_out = addr_in[ADDR_BITS-1:`FSM_SECTOR_BITS];
  assign block32_out = addr_in[ADDR_BITS-1:`FSM_BLK32_BITS];
  assign block64_out = addr_in[ADDR_BITS-1:`FSM_BLK64_BITS];
endmodule // fsm_sector_decode

// ---- src/fsm_status_core.v ----
`timescale 1ns/1ps
`include "fsm_map.vh"
module fsm_status_core #(
  parameter ADDR_BITS = 19,
  parameter WRITE_CYC = `FSM_WRITE_CYC
) (
  input wire clk_in,
  input wire rst_in,
  input wire sck_in,
  input wire ce_n_in,
  input wire si_in,
  input wire wp_n_in,
  output reg so_out,
  output reg so_oe_out,
  output reg [7:0] status_out,
  output reg [7:0] function_out,
  output reg [ADDR_BITS-13:0] sector_out,
  output reg [ADDR_BITS-16:0] block32_out,
  output reg [ADDR_BITS-17:0] block64_out,
  output reg protect_hit_out
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [1:0] sck_s_q;
  reg [1:0] ce_s_q;
  reg [1:0] si_s_q;
  reg [1:0] wp_s_q;
  reg sck_d1_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      sck_s_q <= 2'h0;
      ce_s_q <= 2'h3;
      si_s_q <= 2'h0;
      wp_s_q <= 2'h3;
      sck_d1_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], sck_in};
      ce_s_q <= {ce_s_q[0], ce_n_in};
      si_s_q <= {si_s_q[0], si_in};
      wp_s_q <= {wp_s_q[0], wp_n_in};
      sck_d1_q <= sck_s_q[1];
    end
  end
  wire sel = ~ce_s_q[1];
  wire rise = sel & sck_s_q[1] & ~sck_d1_q;
  wire fall = sel & ~sck_s_q[1] & sck_d1_q;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  reg [23:0] addr_q;
  wire [ADDR_BITS-13:0] sec_w;
  wire [ADDR_BITS-16:0] b32_w;
  wire [ADDR_BITS-17:0] b64_w;
  fsm_sector_decode #(.ADDR_BITS(ADDR_BITS)) u_dec (
    .addr_in(addr_q),
    .sector_out(sec_w),
    .block32_out(b32_w),
    .block64_out(b64_w)
  );

  // top-down protection, BP value selects the number of 64 KB regions.
  function prot_hit;
    input [3:0] bp;
    input [ADDR_BITS-17:0] blk;
    reg [4:0] top;
    begin
      top = 5'h1 << (ADDR_BITS - 16);
      prot_hit = (bp != 4'h0) && (({1'b0, bp} >= top) || ({27'h0, blk} >= ({27'h0, top} - {28'h0, bp})));
    end
  endfunction

  // ----------------------------------------
  // Serial command engine
  // ----------------------------------------
  localparam ST_CMD = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;
  localparam ST_READ = 2'h3;
  reg [1:0] st_q;
  reg [4:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] cmd_q;
  reg [7:0] sr_q;
  reg [7:0] fr_q;
  reg [7:0] tx_q;
  reg pend_q;
  reg [7:0] new_sr_q;
  reg [15:0] busy_q;
  wire [7:0] sh_n = {sh_q[6:0], si_s_q[1]};
  // The protection test needs the address with its last bit already shifted in.
  wire [23:0] addr_n = {addr_q[22:0], si_s_q[1]};
  wire locked = sr_q[`FSM_SR_LOCK] & ~wp_s_q[1];
  wire busy = sr_q[`FSM_SR_BUSY];
  always @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= ST_CMD;
      cnt_q <= 5'h0;
      sh_q <= 8'h0;
      cmd_q <= 8'h0;
      sr_q <= `FSM_SR_RESET;
      fr_q <= 8'h00;
      tx_q <= 8'h0;
      pend_q <= 1'b0;
      new_sr_q <= 8'h0;
      busy_q <= 16'h0;
      addr_q <= 24'h0;
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
      status_out <= `FSM_SR_RESET;
      function_out <= 8'h00;
      sector_out <= {(ADDR_BITS-12){1'b0}};
      block32_out <= {(ADDR_BITS-15){1'b0}};
      block64_out <= {(ADDR_BITS-16){1'b0}};
      protect_hit_out <= 1'b0;
    end else begin
      status_out <= sr_q;
      function_out <= fr_q;
      sector_out <= sec_w;
      block32_out <= b32_w;
      block64_out <= b64_w;
      protect_hit_out <= prot_hit(sr_q[`FSM_SR_BP_HI:`FSM_SR_BP_LO], b64_w);
      // busy timer runs the write cycle, then clears busy and the latch.
      if (busy) begin
        if (busy_q <= 16'h1) begin
          sr_q[`FSM_SR_BUSY] <= 1'b0;
          sr_q[`FSM_SR_WR_LATCH] <= 1'b0;
        end else begin
          busy_q <= busy_q - 16'h1;
        end
      end
      if (!sel) begin
        // frame end commits a pending write unless it is a status write while locked
        st_q <= ST_CMD;
        cnt_q <= 5'h0;
        so_oe_out <= 1'b0;
        if (pend_q) begin
          pend_q <= 1'b0;
          if (cmd_q != `FSM_CMD_STATUS_WR || !locked) begin
            sr_q[`FSM_SR_BUSY] <= 1'b1;
            busy_q <= WRITE_CYC[15:0];
            if (cmd_q == `FSM_CMD_STATUS_WR) begin
              sr_q[7:2] <= new_sr_q[7:2];
            end
          end
        end
      end else if (rise) begin
        sh_q <= sh_n;
        cnt_q <= cnt_q + 5'h1;
        case (st_q)
          ST_CMD: begin
            if (cnt_q == 5'h7) begin
              cnt_q <= 5'h0;
              cmd_q <= sh_n;
              if (sh_n == `FSM_CMD_WR_ENABLE && !busy) begin
                sr_q[`FSM_SR_WR_LATCH] <= 1'b1;
              end else if (sh_n == `FSM_CMD_WR_DISABLE && !busy) begin
                sr_q[`FSM_SR_WR_LATCH] <= 1'b0;
              end
              if (sh_n == `FSM_CMD_STATUS_RD) begin
                st_q <= ST_READ;
                tx_q <= sr_q;
              end else if (sh_n == `FSM_CMD_STATUS_WR) begin
                st_q <= ST_DATA;
              end else if (sh_n == `FSM_CMD_SE || sh_n == `FSM_CMD_PP) begin
                st_q <= ST_ADDR;
              end else begin
                st_q <= ST_CMD;
                cnt_q <= 5'h0;
              end
            end
          end
          ST_ADDR: begin
            addr_q <= addr_n;
            if (cnt_q == 5'h17) begin
              st_q <= ST_DATA;
              cnt_q <= 5'h0;
              // protected or not enabled ops are dropped
              pend_q <= sr_q[`FSM_SR_WR_LATCH] & ~busy &
                ~prot_hit(sr_q[`FSM_SR_BP_HI:`FSM_SR_BP_LO], addr_n[ADDR_BITS-1:`FSM_BLK64_BITS]);
            end
          end
          ST_DATA: begin
            if (cnt_q == 5'h7 && cmd_q == `FSM_CMD_STATUS_WR) begin
              new_sr_q <= sh_n;
              pend_q <= sr_q[`FSM_SR_WR_LATCH] & ~busy;
            end
          end
          default: begin
            st_q <= ST_READ;
          end
        endcase
      end else if (fall && st_q == ST_READ) begin
        // drive on falling edge, status repeats live.
        so_oe_out <= 1'b1;
        if (cnt_q[2:0] == 3'h0) begin
          so_out <= sr_q[7];
          tx_q <= {sr_q[6:0], 1'b0};
        end else begin
          so_out <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule // fsm_status_core

// ---- testbench/fsm_spi_host.sv ----
`timescale 1ns/1ps
module fsm_spi_host (
  input wire clk_in,
  input wire so_in,
  output reg sck_out,
  output reg ce_n_out,
  output reg si_out
);
  // Clock level between frames: low for mode 0, high for mode 3.
  reg idle_lvl = 1'b0;
  initial begin
    sck_out = 1'b0;
    ce_n_out = 1'b1;
    si_out = 1'b0;
  end
  task start;
    begin
      sck_out = idle_lvl;
      repeat (2) @(negedge clk_in);
      ce_n_out = 1'b0;
      repeat (4) @(negedge clk_in);
    end
  endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sck_out = 1'b0;
        si_out = tx[i];
        repeat (4) @(negedge clk_in);
        rx[i] = so_in;
        sck_out = 1'b1;
        repeat (4) @(negedge clk_in);
      end
    end
  endtask
  // Between frames the data line toggles so a stale level is never trusted.
  task stop;
    begin
      sck_out = idle_lvl;
      repeat (4) @(negedge clk_in);
      ce_n_out = 1'b1;
      si_out = ~si_out;
      repeat (8) @(negedge clk_in);
    end
  endtask
endmodule // fsm_spi_host

// ---- testbench/fsm_status_checker.sv ----
`timescale 1ns/1ps
module fsm_status_checker #(
  parameter ADDR_BITS = 19,
  parameter WRITE_CYC = 20
) (
  input wire clk_in,
  input wire rst_in,
  input wire ce_n_in,
  input wire wp_n_in,
  input wire so_oe_out,
  input wire [7:0] status_out,
  input wire [7:0] function_out,
  input wire [ADDR_BITS-13:0] sector_out,
  input wire [ADDR_BITS-16:0] block32_out,
  input wire [ADDR_BITS-17:0] block64_out
);
  // Counts how long the busy flag has stood.
  reg [15:0] busy_q;
  always @(posedge clk_in) begin
    busy_q <= (rst_in || !status_out[0]) ? 16'h0000 : busy_q + 16'h0001;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_function_zero: assert property (function_out == 8'h00)
    else $error("function register not zero");
  a_block32_map: assert property (sector_out[ADDR_BITS-13:3] == block32_out)
    else $error("block32 index differs from sector index");
  a_block64_map: assert property (block32_out[ADDR_BITS-16:1] == block64_out)
    else $error("block64 index differs from block32 index");
  a_busy_length: assert property (busy_q <= WRITE_CYC + 2)
    else $error("busy flag stood too long");
  a_busy_needs_wel: assert property ($rose(status_out[0]) |-> $past(status_out[1]))
    else $error("write cycle began without write enable");
  a_wel_autoclear: assert property ($fell(status_out[0]) |-> ##[0:1] !status_out[1])
    else $error("write enable kept after write");
  a_oe_release: assert property (ce_n_in [*5] |-> !so_oe_out)
    else $error("serial output driven while deselected");
  a_lock_holds: assert property ((status_out[7] && !wp_n_in) [*4] |=> $stable(status_out[7:2]))
    else $error("locked status bits changed");
endmodule // fsm_status_checker
bind fsm_status_core fsm_status_checker #(.ADDR_BITS(ADDR_BITS), .WRITE_CYC(WRITE_CYC)) i_chk (
  .clk_in(clk_in), .rst_in(rst_in), .ce_n_in(ce_n_in), .wp_n_in(wp_n_in), .so_oe_out(so_oe_out),
  .status_out(status_out), .function_out(function_out), .sector_out(sector_out),
  .block32_out(block32_out), .block64_out(block64_out));

// ---- testbench/fsm_status_core_bench.sv ----
`timescale 1ns/1ps
module fsm_status_core_bench;
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg wp_n_in = 1'b1;
  wire sck, ce_n, si, so, so_oe, so_line, hit;
  wire [7:0] status;
  wire [6:0] sector;
  wire [3:0] blk32;
  wire [2:0] blk64;
  integer num_errors = 0;
  integer check_count = 0;
  reg [7:0] rd;
  initial forever #25 clk_in = ~clk_in;
  // A released output shows the inverse level, so a stale bit is never trusted.
  assign so_line = so_oe ? so : ~so;
  fsm_spi_host i_host (.clk_in(clk_in), .so_in(so_line), .sck_out(sck), .ce_n_out(ce_n), .si_out(si));
  fsm_status_core #(.ADDR_BITS(19), .WRITE_CYC(200)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .sck_in(sck), .ce_n_in(ce_n), .si_in(si), .wp_n_in(wp_n_in), .so_out(so), .so_oe_out(so_oe),
    .status_out(status), .function_out(), .sector_out(sector), .block32_out(blk32),
    .block64_out(blk64), .protect_hit_out(hit));
  task chk(input [47:0] what, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task cmd(input [7:0] op);
    begin
      i_host.start;
      i_host.xfer(op, rd);
      i_host.stop;
    end
  endtask
  task rdsr(input [7:0] e);
    begin
      i_host.start;
      i_host.xfer(8'h05, rd);
      i_host.xfer(8'h00, rd);
      i_host.stop;
      chk("rdsr", e, rd);
      chk("status", e, status);
    end
  endtask
  task status_write_cmd(input [7:0] v);
    begin
      i_host.start;
      i_host.xfer(8'h01, rd);
      i_host.xfer(v, rd);
      i_host.stop;
    end
  endtask
  task erase(input [23:0] a);
    begin
      cmd(8'h06);
      i_host.start;
      i_host.xfer(8'h20, rd);
      i_host.xfer(a[23:16], rd);
      i_host.xfer(a[15:8], rd);
      i_host.xfer(a[7:0], rd);
      i_host.stop;
      repeat (250) @(negedge clk_in);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors = num_errors + 1;
    stop_test;
  end
  initial begin
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    rdsr(8'h00);
    cmd(8'h06);
    rdsr(8'h02);
    cmd(8'h04);
    rdsr(8'h00);
    status_write_cmd(8'h3c);
    rdsr(8'h00);
    cmd(8'h06);
    status_write_cmd(8'h80);
    rdsr(8'h83);
    repeat (250) @(negedge clk_in);
    rdsr(8'h80);
    wp_n_in = 1'b0;
    cmd(8'h06);
    status_write_cmd(8'h00);
    repeat (250) @(negedge clk_in);
    chk("lock", 8'h80, {status[7:2], 2'b00});
    rdsr(8'h82);
    wp_n_in = 1'b1;
    cmd(8'h06);
    status_write_cmd(8'h00);
    repeat (250) @(negedge clk_in);
    rdsr(8'h00);
    erase(24'h07f123);
    chk("sector", 8'h7f, {1'b0, sector});
    chk("blk32", 8'h0f, {4'h0, blk32});
    chk("blk64", 8'h07, {5'h00, blk64});
    chk("hit", 8'h00, {7'h00, hit});
    erase(24'hf81000);
    chk("high", 8'h01, {1'b0, sector});
    cmd(8'h06);
    status_write_cmd(8'h04);
    repeat (250) @(negedge clk_in);
    erase(24'h07f123);
    chk("hit", 8'h01, {7'h00, hit});
    rdsr(8'h06);
    erase(24'h010000);
    chk("hit", 8'h00, {7'h00, hit});
    rdsr(8'h04);
    i_host.idle_lvl = 1'b1;
    rdsr(8'h04);
    stop_test;
  end
endmodule // fsm_status_core_bench
